// file: common/rail_seq_map.svh
// Register offsets, field positions, reset values and timing constants
`ifndef RAIL_SEQ_MAP_SVH
`define RAIL_SEQ_MAP_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define REG_RAIL_ENABLE_CONTROL  8'h02
`define REG_FAULT_FLAGS          8'h04
`define REG_PROTECT_CONFIG       8'h05

// ****************************************************************
// Field positions
// ****************************************************************
`define BIT_NEG_RAIL_EN          1
`define BIT_POS_RAIL_EN          2
`define BIT_SEQ_DELAY_DISABLE    6
`define BIT_FAULT_OVERTEMP       0
`define BIT_FAULT_BOOST_UV       1
`define BIT_FAULT_NEG_UV         2
`define BIT_FAULT_POS_UV         3
`define BIT_UV_PROTECT_DISABLE   5

// ****************************************************************
// Reset values
// ****************************************************************
`define RST_RAIL_ENABLE_CONTROL  8'h07
`define RST_FAULT_FLAGS          8'h00
`define RST_PROTECT_CONFIG       8'h00

// ****************************************************************
// Timing
// ****************************************************************
`define CLK_FREQ_HZ              125000000
`define SEQ_DELAY_US             2000
`define UV_WINDOW_US             100
`define SEQ_DELAY_CYCLES  ((`SEQ_DELAY_US * (`CLK_FREQ_HZ / 1000000)))
`define UV_WINDOW_CYCLES  ((`UV_WINDOW_US * (`CLK_FREQ_HZ / 1000000)))

`endif

// file: common/rail_seq_pkg.sv
// Types shared by the rail sequencer and its register port
package rail_seq_pkg;

	// One bit per regulator
	typedef struct packed {
		logic boost;
		logic pos;
		logic neg;
	} rail_vec_t;

	// Register access from the serial interface layer
	typedef struct packed {
		logic       wr;
		logic       stop;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} reg_req_t;

endpackage : rail_seq_pkg

// file: src/delay_timer.sv
// Restartable qualification counter
module delay_timer #(
	parameter int CYCLES = 250000
) (
	input  wire logic clk_sys,
	input  wire logic rst,
	input  wire logic run,
	output logic      done
);
	localparam int W = $clog2(CYCLES + 1);
	localparam logic [W-1:0] LAST = W'(CYCLES - 1);

	logic [W-1:0] count;

	// Counter clears whenever run drops
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			count <= '0;
			done  <= 1'b0;
		end else if (!run) begin
			count <= '0;
			done  <= 1'b0;
		end else if (count == LAST) begin
			done <= 1'b1;
		end else begin
			count <= count + W'(1);
		end
	end

endmodule : delay_timer

// file: src/rail_enable_sequencer_fault_monitor.sv
// Rail enable sequencing, register file and fault monitoring
`include "rail_seq_map.svh"

module rail_enable_sequencer_fault_monitor #(
	parameter int SEQ_DELAY_CYCLES = `SEQ_DELAY_CYCLES,
	parameter int UV_WINDOW_CYCLES = `UV_WINDOW_CYCLES
) (
	input  wire logic                  clk_sys,
	input  wire logic                  rst,
	input  wire logic                  pos_rail_enable_pin,
	input  wire logic                  neg_rail_enable_pin,
	input  wire rail_seq_pkg::reg_req_t reg_req,
	output logic [7:0]                 reg_rdata,
	input  wire logic                  input_undervolt_lockout,
	input  wire logic                  overtemp_active,
	input  wire logic                  boost_softstart_done,
	input  wire rail_seq_pkg::rail_vec_t uv_sense,
	input  wire logic                  overcurrent_limit,
	input  wire logic                  switch_cycle_start,
	input  wire logic                  switch_pwm,
	output logic                       boost_switch_gate,
	output rail_seq_pkg::rail_vec_t    rail_en
);
	import rail_seq_pkg::*;

	logic [7:0] rail_enable_control;
	logic [7:0] fault_flags;
	logic [7:0] protect_config;
	logic [7:0] staged_data;
	logic [7:0] staged_addr;
	logic       staged_valid;
	logic       otp_read_once;
	logic       pos_req;
	logic       neg_req;
	logic       pos_req_d;
	logic       neg_req_d;
	logic       pins_low_seen;
	logic       joint_clear;
	logic       joint_start;
	logic       joint_fall;
	logic       pos_keep;
	logic       pos_hold;
	logic       pos_hold_done;
	logic       neg_delay_done;
	logic       supply_ok;
	logic       uv_enable;
	logic       oc_cut;
	rail_vec_t  next_rail_en;
	rail_vec_t  uv_done;
	rail_vec_t  uv_run;

	// ****************************************************************
	// Register writes committed at STOP
	// ****************************************************************
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			staged_valid <= 1'b0;
			staged_addr  <= 8'h00;
			staged_data  <= 8'h00;
		end else if (reg_req.stop) begin
			staged_valid <= 1'b0;
		end else if (reg_req.wr) begin
			staged_valid <= 1'b1;
			staged_addr  <= reg_req.addr;
			staged_data  <= reg_req.wdata;
		end
	end

	// Reset only by power loss, never by input lockout
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			rail_enable_control <= `RST_RAIL_ENABLE_CONTROL;
			protect_config      <= `RST_PROTECT_CONFIG;
		end else if (reg_req.stop && staged_valid) begin
			if (staged_addr == `REG_RAIL_ENABLE_CONTROL) begin
				rail_enable_control <= staged_data;
			end else if (staged_addr == `REG_PROTECT_CONFIG) begin
				protect_config <= staged_data;
			end
		end
	end

	// ****************************************************************
	// Register reads
	// ****************************************************************
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			reg_rdata <= 8'h00;
		end else if (reg_req.rd) begin
			if (reg_req.addr == `REG_RAIL_ENABLE_CONTROL) begin
				reg_rdata <= rail_enable_control;
			end else if (reg_req.addr == `REG_FAULT_FLAGS) begin
				reg_rdata <= fault_flags;
			end else if (reg_req.addr == `REG_PROTECT_CONFIG) begin
				reg_rdata <= protect_config;
			end else begin
				reg_rdata <= 8'h00;
			end
		end
	end

	// Counts reads of the fault register while the flag is set
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			otp_read_once <= 1'b0;
		end else if (!fault_flags[`BIT_FAULT_OVERTEMP]) begin
			otp_read_once <= 1'b0;
		end else if (reg_req.rd && reg_req.addr == `REG_FAULT_FLAGS) begin
			otp_read_once <= !otp_read_once;
		end
	end

	// ****************************************************************
	// Pin requests and joint pin cycle
	// ****************************************************************
	assign pos_req = pos_rail_enable_pin
		&& rail_enable_control[`BIT_POS_RAIL_EN];
	assign neg_req = neg_rail_enable_pin
		&& rail_enable_control[`BIT_NEG_RAIL_EN];

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			pos_req_d <= 1'b0;
			neg_req_d <= 1'b0;
		end else begin
			pos_req_d <= pos_req;
			neg_req_d <= neg_req;
		end
	end

	// Both pins low together, then both high together
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			pins_low_seen <= 1'b0;
		end else if (!pos_rail_enable_pin && !neg_rail_enable_pin) begin
			pins_low_seen <= 1'b1;
		end else if (pos_rail_enable_pin != neg_rail_enable_pin) begin
			pins_low_seen <= 1'b0;
		end else begin
			pins_low_seen <= 1'b0;
		end
	end

	assign joint_clear = pins_low_seen
		&& pos_rail_enable_pin && neg_rail_enable_pin;

	// ****************************************************************
	// Fault flags
	// ****************************************************************
	assign uv_enable = !overtemp_active
		&& !protect_config[`BIT_UV_PROTECT_DISABLE];
	assign uv_run.boost = uv_enable && rail_en.boost && uv_sense.boost;
	assign uv_run.pos   = uv_enable && rail_en.pos && uv_sense.pos;
	assign uv_run.neg   = uv_enable && rail_en.neg && uv_sense.neg;

	delay_timer #(.CYCLES(UV_WINDOW_CYCLES)) u_uv_boost (
		.clk_sys (clk_sys),
		.rst     (rst),
		.run     (uv_run.boost),
		.done    (uv_done.boost)
	);

	delay_timer #(.CYCLES(UV_WINDOW_CYCLES)) u_uv_pos (
		.clk_sys (clk_sys),
		.rst     (rst),
		.run     (uv_run.pos),
		.done    (uv_done.pos)
	);

	delay_timer #(.CYCLES(UV_WINDOW_CYCLES)) u_uv_neg (
		.clk_sys (clk_sys),
		.rst     (rst),
		.run     (uv_run.neg),
		.done    (uv_done.neg)
	);

	// Sets win over clears; bits 7:4 stay zero
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			fault_flags <= `RST_FAULT_FLAGS;
		end else begin
			if (overtemp_active) begin
				fault_flags[`BIT_FAULT_OVERTEMP] <= 1'b1;
			end else if (joint_clear) begin
				fault_flags[`BIT_FAULT_OVERTEMP] <= 1'b0;
			end else if (reg_req.rd && reg_req.addr == `REG_FAULT_FLAGS
				&& otp_read_once) begin
				fault_flags[`BIT_FAULT_OVERTEMP] <= 1'b0;
			end
			if (uv_done.boost) begin
				fault_flags[`BIT_FAULT_BOOST_UV] <= 1'b1;
			end else if (joint_clear) begin
				fault_flags[`BIT_FAULT_BOOST_UV] <= 1'b0;
			end
			if (uv_done.neg) begin
				fault_flags[`BIT_FAULT_NEG_UV] <= 1'b1;
			end else if (joint_clear) begin
				fault_flags[`BIT_FAULT_NEG_UV] <= 1'b0;
			end
			if (uv_done.pos) begin
				fault_flags[`BIT_FAULT_POS_UV] <= 1'b1;
			end else if (joint_clear) begin
				fault_flags[`BIT_FAULT_POS_UV] <= 1'b0;
			end
		end
	end

	// ****************************************************************
	// Sequencing delays
	// ****************************************************************
	// Joint start: both requests rise in the same cycle
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			joint_start <= 1'b0;
		end else if (!neg_req) begin
			joint_start <= 1'b0;
		end else if (pos_req && !pos_req_d && !neg_req_d) begin
			joint_start <= 1'b1;
		end
	end

	delay_timer #(.CYCLES(SEQ_DELAY_CYCLES)) u_neg_delay (
		.clk_sys (clk_sys),
		.rst     (rst),
		.run     (joint_start && rail_en.pos),
		.done    (neg_delay_done)
	);

	// Both requests drop together with sequencing enabled
	assign joint_fall = pos_req_d && neg_req_d && !pos_req && !neg_req
		&& !rail_enable_control[`BIT_SEQ_DELAY_DISABLE];

	// Keeps positive rail up from the very edge of a joint stop
	assign pos_keep = pos_hold || (joint_fall && rail_en.pos);

	// Joint stop: positive rail held 2 ms after negative shuts down
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			pos_hold <= 1'b0;
		end else if (pos_req || pos_hold_done || !supply_ok) begin
			pos_hold <= 1'b0;
		end else if (joint_fall) begin
			pos_hold <= rail_en.pos;
		end
	end

	delay_timer #(.CYCLES(SEQ_DELAY_CYCLES)) u_pos_hold (
		.clk_sys (clk_sys),
		.rst     (rst),
		.run     (pos_hold),
		.done    (pos_hold_done)
	);

	// ****************************************************************
	// Rail enables
	// ****************************************************************
	assign supply_ok = !input_undervolt_lockout
		&& !overtemp_active;

	always_comb begin
		next_rail_en.boost = supply_ok
			&& (pos_req || neg_req || pos_keep)
			&& !fault_flags[`BIT_FAULT_BOOST_UV];
		next_rail_en.pos = supply_ok && boost_softstart_done
			&& next_rail_en.boost && (pos_req || pos_keep)
			&& !fault_flags[`BIT_FAULT_POS_UV];
		next_rail_en.neg = supply_ok && boost_softstart_done
			&& next_rail_en.boost && neg_req
			&& !fault_flags[`BIT_FAULT_NEG_UV]
			&& (!joint_start || neg_delay_done || rail_en.neg
			|| rail_enable_control[`BIT_SEQ_DELAY_DISABLE]);
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			rail_en <= '0;
		end else begin
			rail_en <= next_rail_en;
		end
	end

	// ****************************************************************
	// Cycle-by-cycle current limit
	// ****************************************************************
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			oc_cut <= 1'b0;
		end else if (overcurrent_limit) begin
			oc_cut <= 1'b1;
		end else if (switch_cycle_start) begin
			oc_cut <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			boost_switch_gate <= 1'b0;
		end else begin
			boost_switch_gate <= switch_pwm && rail_en.boost
				&& !oc_cut && !overcurrent_limit;
		end
	end

endmodule : rail_enable_sequencer_fault_monitor

// file: test/rail_seq_assertions.sv
// Port checks for the rail sequencer
module rail_seq_checker #(
	parameter int SEQ_DELAY_CYCLES = 20
) (
	input wire logic                    clk_sys,
	input wire logic                    rst,
	input wire logic                    pos_rail_enable_pin,
	input wire logic                    neg_rail_enable_pin,
	input wire logic                    input_undervolt_lockout,
	input wire logic                    overtemp_active,
	input wire logic                    boost_softstart_done,
	input wire logic                    overcurrent_limit,
	input wire logic                    switch_cycle_start,
	input wire logic                    switch_pwm,
	input wire logic                    boost_switch_gate,
	input wire rail_seq_pkg::rail_vec_t rail_en
);
	import rail_seq_pkg::*;
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (rst);
	int low_cnt;
	// ********
	// Cycles with the positive pin low
	// ********
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			low_cnt <= 0;
		end else begin
			low_cnt <= pos_rail_enable_pin ? 0 : low_cnt + 1;
		end
	end
	a_lockout_all_off: assert property (
		input_undervolt_lockout |=> rail_en == 3'h0)
		else $error("rail on in lockout");
	a_overtemp_all_off: assert property (
		overtemp_active |=> rail_en == 3'h0)
		else $error("rail on in overtemp");
	a_pos_start_cause: assert property (
		$rose(rail_en.pos) |-> $past(boost_softstart_done)
		&& $past(pos_rail_enable_pin))
		else $error("positive rail started early");
	a_neg_pin_off: assert property (
		!neg_rail_enable_pin |=> !rail_en.neg)
		else $error("negative rail ignores pin");
	a_boost_with_rail: assert property (
		rail_en.pos || rail_en.neg |-> rail_en.boost)
		else $error("rail on without boost");
	a_gate_limit_cut: assert property (
		overcurrent_limit && !switch_cycle_start |=> !boost_switch_gate)
		else $error("gate on at current limit");
	a_gate_pwm_source: assert property (
		boost_switch_gate |-> $past(switch_pwm))
		else $error("gate without pwm");
	a_pos_off_bound: assert property (
		low_cnt > SEQ_DELAY_CYCLES + 4 |-> !rail_en.pos)
		else $error("positive rail stuck on");
endmodule : rail_seq_checker

bind rail_enable_sequencer_fault_monitor rail_seq_checker #(
	.SEQ_DELAY_CYCLES(SEQ_DELAY_CYCLES)
) u_chk (
	.clk_sys, .rst, .pos_rail_enable_pin, .neg_rail_enable_pin,
	.input_undervolt_lockout, .overtemp_active, .boost_softstart_done,
	.overcurrent_limit, .switch_cycle_start, .switch_pwm,
	.boost_switch_gate, .rail_en
);

// file: test/rail_host_model.sv
// Host model: enable pins and register strobes
module rail_host_model (
	input  wire logic              clk_sys,
	input  wire logic [7:0]        reg_rdata,
	output logic                   pos_rail_enable_pin,
	output logic                   neg_rail_enable_pin,
	output rail_seq_pkg::reg_req_t reg_req
);
	import rail_seq_pkg::*;
	initial begin
		pos_rail_enable_pin = 1'b0;
		neg_rail_enable_pin = 1'b0;
		reg_req = '0;
	end
	task pin_set(input logic p, input logic n);
		@(posedge clk_sys);
		pos_rail_enable_pin <= p;
		neg_rail_enable_pin <= n;
	endtask : pin_set
	task reg_stage(input logic [7:0] a, input logic [7:0] v);
		@(posedge clk_sys);
		reg_req.addr <= a;
		reg_req.wdata <= v;
		reg_req.wr <= 1'b1;
		@(posedge clk_sys);
		reg_req.wr <= 1'b0;
		reg_req.addr <= ~a;
		reg_req.wdata <= ~v;
	endtask : reg_stage
	task reg_commit;
		@(posedge clk_sys);
		reg_req.stop <= 1'b1;
		@(posedge clk_sys);
		reg_req.stop <= 1'b0;
	endtask : reg_commit
	task reg_wr(input logic [7:0] a, input logic [7:0] v);
		reg_stage(a, v);
		reg_commit();
	endtask : reg_wr
	task reg_rd(input logic [7:0] a, output logic [7:0] v);
		@(posedge clk_sys);
		reg_req.addr <= a;
		reg_req.rd <= 1'b1;
		@(posedge clk_sys);
		reg_req.rd <= 1'b0;
		reg_req.addr <= ~a;
		@(negedge clk_sys);
		v = reg_rdata;
	endtask : reg_rd
endmodule : rail_host_model

// file: test/tb_rail_enable_sequencer_fault_monitor.sv
// Self-checking bench for the rail sequencer
module tb_rail_enable_sequencer_fault_monitor;
	timeunit 1ns;
	timeprecision 1ps;
	import rail_seq_pkg::*;
	logic       clk_sys = 1'b0;
	logic       rst = 1'b1;
	logic       pos_rail_enable_pin, neg_rail_enable_pin;
	reg_req_t   reg_req;
	logic [7:0] reg_rdata, d;
	logic       input_undervolt_lockout = 1'b0, overtemp_active = 1'b0;
	logic       boost_softstart_done = 1'b0, overcurrent_limit = 1'b0;
	logic       switch_cycle_start = 1'b0, switch_pwm = 1'b0;
	logic       boost_switch_gate;
	rail_vec_t  uv_sense = 3'h0, rail_en;
	int         errors = 0, check_count = 0, cycles = 0;
	rail_enable_sequencer_fault_monitor #(
		.SEQ_DELAY_CYCLES(20), .UV_WINDOW_CYCLES(10)
	) u_dut (
		.clk_sys, .rst, .pos_rail_enable_pin, .neg_rail_enable_pin,
		.reg_req, .reg_rdata, .input_undervolt_lockout, .overtemp_active,
		.boost_softstart_done, .uv_sense, .overcurrent_limit,
		.switch_cycle_start, .switch_pwm, .boost_switch_gate, .rail_en
	);
	rail_host_model u_host (
		.clk_sys, .reg_rdata, .pos_rail_enable_pin, .neg_rail_enable_pin,
		.reg_req
	);
	always #4 clk_sys = ~clk_sys;
	always @(posedge clk_sys) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			errors++;
			wrap_up();
		end
	end
	// ********
	// Helpers
	// ********
	task wrap_up;
		if (errors == 0 && check_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : wrap_up
	task chk(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task idle(input int n);
		repeat (n) @(negedge clk_sys);
	endtask : idle
	task rails(input int n, input logic [2:0] e);
		idle(n);
		chk({5'h00, rail_en}, {5'h00, e});
	endtask : rails
	task rchk(input logic [7:0] a, input logic [7:0] e);
		u_host.reg_rd(a, d);
		chk(d, e);
	endtask : rchk
	task uv_pos(input int n);
		@(posedge clk_sys);
		uv_sense.pos <= 1'b1;
		repeat (n) @(posedge clk_sys);
		uv_sense.pos <= 1'b0;
	endtask : uv_pos
	task cyc_start;
		@(posedge clk_sys);
		switch_cycle_start <= 1'b1;
		@(posedge clk_sys);
		switch_cycle_start <= 1'b0;
	endtask : cyc_start
	// ********
	// Scenarios
	// ********
	task t_reset_regs;
		rchk(8'h02, 8'h07);
		rchk(8'h04, 8'h00);
		rchk(8'h05, 8'h00);
		rchk(8'h03, 8'h00);
		u_host.reg_wr(8'h04, 8'hFF);
		rchk(8'h04, 8'h00);
	endtask : t_reset_regs
	task t_power_on;
		u_host.pin_set(1'b1, 1'b1);
		rails(5, 3'h4);
		@(posedge clk_sys);
		boost_softstart_done <= 1'b1;
		rails(3, 3'h6);
		rails(10, 3'h6);
		rails(30, 3'h7);
		u_host.pin_set(1'b0, 1'b0);
		rails(2, 3'h6);
		rails(15, 3'h6);
		rails(15, 3'h0);
		u_host.pin_set(1'b1, 1'b1);
		rails(40, 3'h7);
		u_host.pin_set(1'b1, 1'b0);
		rails(3, 3'h6);
		u_host.pin_set(1'b1, 1'b1);
		rails(3, 3'h7);
	endtask : t_power_on
	task t_uv;
		uv_pos(5);
		rails(3, 3'h7);
		uv_pos(20);
		rails(3, 3'h5);
		rchk(8'h04, 8'h08);
		u_host.pin_set(1'b0, 1'b0);
		idle(40);
		u_host.pin_set(1'b1, 1'b1);
		rails(40, 3'h7);
		rchk(8'h04, 8'h00);
		u_host.reg_wr(8'h05, 8'h20);
		uv_pos(20);
		rails(3, 3'h7);
		u_host.reg_wr(8'h05, 8'h00);
	endtask : t_uv
	task t_overtemp;
		@(posedge clk_sys);
		overtemp_active <= 1'b1;
		uv_sense <= 3'h7;
		rails(20, 3'h0);
		rchk(8'h02, 8'h07);
		@(posedge clk_sys);
		uv_sense <= 3'h0;
		@(posedge clk_sys);
		overtemp_active <= 1'b0;
		rails(40, 3'h7);
		rchk(8'h04, 8'h01);
		u_host.reg_rd(8'h04, d);
		rchk(8'h04, 8'h00);
	endtask : t_overtemp
	task t_lockout;
		u_host.reg_wr(8'h02, 8'h47);
		@(posedge clk_sys);
		input_undervolt_lockout <= 1'b1;
		rails(3, 3'h0);
		@(posedge clk_sys);
		input_undervolt_lockout <= 1'b0;
		rails(40, 3'h7);
		rchk(8'h02, 8'h47);
	endtask : t_lockout
	task t_ocp;
		@(posedge clk_sys);
		switch_pwm <= 1'b1;
		cyc_start();
		idle(3);
		chk({7'h00, boost_switch_gate}, 8'h01);
		@(posedge clk_sys);
		overcurrent_limit <= 1'b1;
		@(posedge clk_sys);
		overcurrent_limit <= 1'b0;
		idle(3);
		chk({7'h00, boost_switch_gate}, 8'h00);
		rails(0, 3'h7);
		cyc_start();
		idle(3);
		chk({7'h00, boost_switch_gate}, 8'h01);
	endtask : t_ocp
	task t_i2c;
		u_host.pin_set(1'b0, 1'b0);
		idle(40);
		u_host.reg_wr(8'h02, 8'h40);
		u_host.pin_set(1'b1, 1'b1);
		rails(5, 3'h0);
		u_host.reg_stage(8'h02, 8'h46);
		rails(3, 3'h0);
		u_host.reg_commit();
		rails(3, 3'h7);
	endtask : t_i2c
	task t_power_cycle;
		@(posedge clk_sys);
		overtemp_active <= 1'b1;
		@(posedge clk_sys);
		overtemp_active <= 1'b0;
		rchk(8'h04, 8'h01);
		@(posedge clk_sys);
		rst <= 1'b1;
		repeat (2) @(posedge clk_sys);
		rst <= 1'b0;
		rchk(8'h02, 8'h07);
		rchk(8'h04, 8'h00);
		rails(40, 3'h7);
	endtask : t_power_cycle
	initial begin
		repeat (6) @(posedge clk_sys);
		rst <= 1'b0;
		t_reset_regs();
		t_power_on();
		t_uv();
		t_overtemp();
		t_lockout();
		t_ocp();
		t_i2c();
		t_power_cycle();
		wrap_up();
	end
endmodule : tb_rail_enable_sequencer_fault_monitor
